// *** hdl/pmfc_top.sv ***
// panel meter front control: scaling, comparison, keys and indicators
`timescale 1ns/100ps
`default_nettype none
module pmfc_top
  import pmfc_pkg::*;
(
  input  wire  logic               clock,
  input  wire  logic               reset,
  input  wire  pmfc_cfg_t          cfg,
  input  wire  pmfc_keys_t         keys,          // one-cycle key press pulses
  input  wire  logic               sample_valid,
  input  wire  logic signed [31:0] sample_value,  // analog counts or pulse freq
  input  wire  logic signed [31:0] remote_value,
  input  wire  logic               hold_in,
  input  wire  logic               remote_write_en,
  input  wire  logic               teach_enable,
  input  wire  logic               teach_request,
  input  wire  logic               cal_showing,
  input  wire  logic               cal_reading,
  output logic signed [31:0]       display_value,
  output logic [19:0]              display_digits, // bcd, 4'hf blank, 4'ha minus, 4'hb -1
  output logic [2:0]               decimal_point,
  output logic                     display_red,
  output logic [2:0]               level_symbol,
  output logic [2:0]               param_index,
  output logic [2:0]               edit_digit,
  output logic                     editing,
  output logic signed [31:0]       setpoint_one,
  output logic signed [31:0]       setpoint_two,
  output pmfc_status_t             status
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic signed [31:0] clamp_disp(input logic signed [63:0] v);
    if (v > 64'(DISP_MAX))
      clamp_disp = DISP_MAX;
    else if (v < 64'(DISP_MIN))
      clamp_disp = DISP_MIN;
    else
      clamp_disp = v[31:0];
  endfunction

  // upper/lower/band decision with hysteresis around the set value
  function automatic logic cmp_out(input pmfc_cmp_t m, input logic prev,
                                   input logic signed [31:0] v,
                                   input logic signed [31:0] sp,
                                   input logic signed [31:0] lo,
                                   input logic [13:0] h);
    logic signed [31:0] hy;
    hy = {18'h0, h};
    case (m)
      PMFC_CMP_UPPER: cmp_out = prev ? (v > sp - hy) : (v > sp);
      PMFC_CMP_LOWER: cmp_out = prev ? (v < sp + hy) : (v < sp);
      default:        cmp_out = prev ? (v > sp - hy) || (v < lo + hy)
                                     : (v > sp) || (v < lo);
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // flash timebase
  logic [25:0] flash_cnt_r;
  logic        flash_r;
  always_ff @(posedge clock)
  begin
    if (reset || flash_cnt_r == 26'(FLASH_HALF_CYC - 1))
      flash_cnt_r <= 26'h0;
    else
      flash_cnt_r <= flash_cnt_r + 26'h1;
  end
  always_ff @(posedge clock)
  begin
    if (reset)
      flash_r <= 1'b0;
    else if (flash_cnt_r == 26'(FLASH_HALF_CYC - 1))
      flash_r <= ~flash_r;
  end

  ////////////////////////////////////////////////////////////////////////////
  // startup compensation timer, counts tenths of a second
  logic [23:0] tenth_cnt_r;
  logic [9:0]  tenths_r;
  wire         tenth_tick = (tenth_cnt_r == 24'(TENTH_S_CYC - 1));
  wire [9:0]   startup_lim = (cfg.startup_tenths > STARTUP_MAX) ? STARTUP_MAX
                                                                 : cfg.startup_tenths;
  wire         is_pulse = (cfg.input_type == PMFC_IN_PULSE_LO) ||
                          (cfg.input_type == PMFC_IN_PULSE_HI);
  wire         startup_done = (tenths_r >= startup_lim);
  always_ff @(posedge clock)
  begin
    if (reset || tenth_tick)
      tenth_cnt_r <= 24'h0;
    else
      tenth_cnt_r <= tenth_cnt_r + 24'h1;
  end
  always_ff @(posedge clock)
  begin
    if (reset)
      tenths_r <= 10'h0;
    else if (tenth_tick && !startup_done)
      tenths_r <= tenths_r + 10'h1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // scaling: two-point linear for analog, factor for pulse
  wire signed [63:0] dx   = 64'(cfg.scale_point_two_in) - 64'(cfg.scale_point_one_in);
  wire signed [63:0] dy   = 64'(cfg.scale_point_two_out) - 64'(cfg.scale_point_one_out);
  wire signed [63:0] rel  = 64'(sample_value) - 64'(cfg.scale_point_one_in);
  // division kept combinational; a zero span falls back to the first output
  wire signed [63:0] lin  = (dx == 64'sh0) ? 64'(cfg.scale_point_one_out)
                          : 64'(cfg.scale_point_one_out) + (rel * dy) / dx;
  wire signed [63:0] pul  = cfg.pulse_scaled
                          ? (64'(sample_value) * 64'(cfg.pulse_factor)) >>> 8
                          : 64'(sample_value);
  wire signed [31:0] scaled = is_pulse ? clamp_disp(pul) : clamp_disp(lin);

  ////////////////////////////////////////////////////////////////////////////
  // averaging: the arriving sample and the three before it, so a fresh
  // reading counts at once instead of lagging one sample behind
  logic signed [31:0] avg_buf_r [AVG_DEPTH - 3'h1];
  wire signed  [33:0] avg_sum = 34'(scaled) + 34'(avg_buf_r[0]) +
                                34'(avg_buf_r[1]) + 34'(avg_buf_r[2]);
  wire signed  [31:0] avg_val = 32'(avg_sum >>> 2);
  always_ff @(posedge clock)
  begin
    if (reset)
      for (int i = 0; i < int'(AVG_DEPTH) - 1; i++)
        avg_buf_r[i] <= 32'sh0;
    else if (sample_valid && !hold_in)
    begin
      avg_buf_r[0] <= scaled;
      for (int i = 1; i < int'(AVG_DEPTH) - 1; i++)
        avg_buf_r[i] <= avg_buf_r[i-1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // measured value, held while hold is asserted except with remote input, shifted by forced zero
  logic signed [31:0] meas_r;
  logic signed [31:0] zero_ofs_r;
  logic               zero_on_r;
  wire signed  [31:0] shown_meas = clamp_disp(64'(meas_r) - 64'(zero_ofs_r));
  wire signed  [31:0] src_val = cfg.avg_enable ? avg_val : scaled;
  always_ff @(posedge clock)
  begin
    if (reset)
      meas_r <= 32'sh0;
    else if (cfg.input_type == PMFC_IN_REMOTE)
      meas_r <= clamp_disp(64'(remote_value));
    else if (sample_valid && !hold_in)
      meas_r <= src_val;
  end

  ////////////////////////////////////////////////////////////////////////////
  // level, parameter and edit navigation
  pmfc_level_t level_r;
  logic [2:0]  param_r;
  logic        edit_r;
  logic [2:0]  digit_r;
  wire         meas_view = (level_r == PMFC_LV_OPER) && (param_r == 3'h0) && !edit_r;
  wire         sp_view   = (level_r == PMFC_LV_OPER) && (param_r != 3'h0);
  wire [2:0]   next_digit = (digit_r == NUM_DIGITS - 3'h1) ? 3'h0 : digit_r + 3'h1;
  always_ff @(posedge clock)
  begin
    if (reset)
      level_r <= PMFC_LV_OPER;
    else if (keys.level)
      level_r <= (level_r == PMFC_LV_CAL) ? PMFC_LV_OPER
                                          : pmfc_level_t'(level_r + 3'h1);
  end
  always_ff @(posedge clock)
  begin
    if (reset || keys.level)
      param_r <= 3'h0;
    else if (keys.mode)
      param_r <= (param_r == NUM_PARAMS - 3'h1) ? 3'h0 : param_r + 3'h1;
  end
  // mode or level leaves editing; shift enters it, then walks digits
  always_ff @(posedge clock)
  begin
    if (reset || keys.level || keys.mode)
    begin
      edit_r  <= 1'b0;
      digit_r <= 3'h0;
    end
    else if (keys.shift && sp_view)
    begin
      edit_r  <= 1'b1;
      digit_r <= edit_r ? next_digit : 3'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // set values: digit increment and teaching
  logic signed [31:0] sp_one_r;
  logic signed [31:0] sp_two_r;
  wire  sel_two = (param_r == 3'h2);
  wire  signed [31:0] sp_sel = sel_two ? sp_two_r : sp_one_r;
  logic signed [31:0] pow10;
  always_comb
  begin
    case (digit_r)
      3'h0:    pow10 = 32'sd1;
      3'h1:    pow10 = 32'sd10;
      3'h2:    pow10 = 32'sd100;
      3'h3:    pow10 = 32'sd1000;
      default: pow10 = 32'sd10000;
    endcase
  end
  // for non-negative values wraps 9 back to 0 in the edited digit, other digits untouched
  wire  [3:0] cur_dig = 4'(((sp_sel < 0 ? -sp_sel : sp_sel) / pow10) % 10);
  wire  signed [31:0] bumped = (cur_dig == DIG_MAX) ? sp_sel - 32'sd9 * pow10
                                                    : sp_sel + pow10;
  wire  teach_go  = teach_enable && teach_request && sp_view;
  wire  bump_go   = keys.up && edit_r;
  wire  signed [31:0] sp_new = teach_go ? shown_meas : clamp_disp(64'(bumped));
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      sp_one_r <= 32'sh0;
      sp_two_r <= 32'sh0;
    end
    else if (teach_go || bump_go)
    begin
      if (sel_two)
        sp_two_r <= sp_new;
      else
        sp_one_r <= sp_new;
    end
  end

  // forced zero toggles only from the measurement view
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      zero_on_r  <= 1'b0;
      zero_ofs_r <= 32'sh0;
    end
    else if (keys.up && meas_view)
    begin
      zero_on_r  <= ~zero_on_r;
      zero_ofs_r <= zero_on_r ? 32'sh0 : meas_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // comparison, startup gating, colour
  logic cmp_one_r;
  logic cmp_two_r;
  wire  gate = !is_pulse || startup_done;
  wire  c1 = cmp_out(cfg.cmp_mode_one, cmp_one_r, shown_meas, sp_one_r, sp_two_r,
                     cfg.hysteresis);
  wire  c2 = cmp_out(cfg.cmp_mode_two, cmp_two_r, shown_meas, sp_two_r, sp_one_r,
                     cfg.hysteresis);
  wire  any_out = c1 || c2;
  logic red_nxt;
  always_comb
  begin
    case (cfg.colour)
      PMFC_COL_G2R: red_nxt = any_out && gate;
      PMFC_COL_R2G: red_nxt = !(any_out && gate);
      PMFC_COL_RED: red_nxt = 1'b1;
      default:      red_nxt = 1'b0;
    endcase
  end
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      cmp_one_r <= 1'b0;
      cmp_two_r <= 1'b0;
    end
    else
    begin
      cmp_one_r <= c1 && gate;
      cmp_two_r <= c2 && gate;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // display digits with leading-zero blanking and sign
  wire  signed [31:0] disp_nxt = sp_view ? sp_sel : shown_meas;
  wire  [31:0] mag = disp_nxt < 0 ? 32'(-disp_nxt) : 32'(disp_nxt);
  logic [19:0] digits_nxt;
  always_comb
  begin
    logic [31:0] q;
    logic        lead;
    q = mag;
    lead = 1'b1;
    digits_nxt = 20'hfffff;
    for (int i = 4; i >= 0; i--)
    begin
      logic [31:0] p;
      p = (i == 4) ? 32'd10000 : (i == 3) ? 32'd1000 : (i == 2) ? 32'd100
        : (i == 1) ? 32'd10 : 32'd1;
      if ((q / p) != 32'h0 || i == 0 || !lead)
      begin
        digits_nxt[i*4 +: 4] = 4'(q / p);
        lead = 1'b0;
      end
      q = q % p;
    end
    // minus sits in the blank just left of the number; a full -19999 has no
    // blank left, so its top place shows minus-one as 4'hb
    if (disp_nxt < 0 && digits_nxt[19:16] != 4'hf)
      digits_nxt[19:16] = 4'hb;
    else if (disp_nxt < 0)
      for (int i = 4; i >= 1; i--)
        if (digits_nxt[i*4 +: 4] == 4'hf && digits_nxt[(i-1)*4 +: 4] != 4'hf)
          digits_nxt[i*4 +: 4] = 4'ha;
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered outputs
  logic [2:0] sym_nxt;
  assign sym_nxt = (level_r == PMFC_LV_OPER) ? SYM_DARK : 3'(level_r);
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      display_value  <= 32'sh0;
      display_digits <= 20'hffff0;
      decimal_point  <= 3'h0;
      display_red    <= 1'b0;
      level_symbol   <= SYM_DARK;
      status         <= '0;
    end
    else
    begin
      display_value  <= disp_nxt;
      display_digits <= digits_nxt;
      decimal_point  <= cfg.decimal_point;
      display_red    <= red_nxt;
      level_symbol   <= sym_nxt;
      status.compare_output_one      <= c1 && gate;
      status.compare_output_two      <= c2 && gate;
      status.setpoint_view_indicator <= sp_view || edit_r;
      status.teach_indicator <= ((teach_go || cal_reading) && flash_r) ||
                                (teach_enable && !teach_request) ||
                                (cal_showing && !cal_reading);
      status.zero_indicator          <= zero_on_r;
      status.hold_indicator          <= hold_in;
      status.remote_write_indicator  <= remote_write_en;
    end
  end
  assign param_index  = param_r;
  assign edit_digit   = digit_r;
  assign editing      = edit_r;
  assign setpoint_one = sp_one_r;
  assign setpoint_two = sp_two_r;

endmodule
`default_nettype wire

// *** shared/pmfc_pkg.sv ***
// constants and carrier types for the panel meter front control
//
// Functional notes
// - light output-one indicator exactly while compare output one is active.
// - light output-two indicator exactly while compare output two is active.
// - set-value indicator lit while a set value is shown or edited.
// - teach indicator steady when enabled or cal shown, flashing when teaching or reading.
// - forced-zero indicator lit while forced-zero shift is active.
// - hold indicator lit while external hold input is asserted.
// - remote-write indicator follows communications write enable.
// - level indicator shows one symbol per level, dark in operation level.
// - level key steps level; mode key steps parameter within level.
// - shift key enters editing; further presses move active digit.
// - up key bumps edited digit; on measurement view it toggles forced zero.
// - four analog ranges; display clamped to -19999..99999 with decimal point.
// - pulse input has low 0.05-30 Hz and high 0.1-5 kHz ranges.
// - remote input type displays host-supplied data.
// - linear scaling from two entered input/display pairs with automatic slope.
// - pulse display is frequency times factor, raw frequency when unscaled.
// - optional averaging of successive samples before display.
// - hysteresis band on each comparison decision prevents chatter.
// - pulse input suppresses outputs until startup time 0.0-99.9 s elapses.
// - four colour modes: green-to-red, red-to-green, fixed red, fixed green.
// - teach request stores present measured value as selected set value.
// - upper, lower and band comparison modes per output.
// - blank leading zeros and show minus sign for negative values.
`default_nettype none
package pmfc_pkg;
  localparam int unsigned CLK_HZ          = 100_000_000;
  localparam int unsigned FLASH_HZ        = 2;
  localparam int unsigned FLASH_HALF_CYC  = CLK_HZ / (FLASH_HZ * 2);
  localparam int unsigned TENTH_S_CYC     = CLK_HZ / 10;
  localparam logic [9:0]  STARTUP_MAX     = 10'h3e7; // 99.9 s in tenths
  localparam logic signed [31:0] DISP_MIN = -32'sd19999;
  localparam logic signed [31:0] DISP_MAX = 32'sd99999;
  localparam logic [2:0]  NUM_DIGITS      = 3'h5;
  localparam logic [2:0]  NUM_PARAMS      = 3'h4;   // parameters per level
  localparam logic [2:0]  AVG_DEPTH       = 3'h4;   // samples averaged
  localparam logic [3:0]  DIG_MAX         = 4'h9;

  // input type and range selection
  typedef enum logic [2:0] {
    PMFC_IN_CURRENT, PMFC_IN_VOLT, PMFC_IN_PM5, PMFC_IN_PM10,
    PMFC_IN_PULSE_LO, PMFC_IN_PULSE_HI, PMFC_IN_REMOTE
  } pmfc_input_t;

  typedef enum logic [1:0] {PMFC_CMP_UPPER, PMFC_CMP_LOWER, PMFC_CMP_BAND} pmfc_cmp_t;

  typedef enum logic [1:0] {
    PMFC_COL_G2R, PMFC_COL_R2G, PMFC_COL_RED, PMFC_COL_GREEN
  } pmfc_colour_t;

  typedef enum logic [2:0] {
    PMFC_LV_OPER, PMFC_LV_PROTECT, PMFC_LV_ADJUST, PMFC_LV_INIT,
    PMFC_LV_COMM, PMFC_LV_ADV, PMFC_LV_CAL
  } pmfc_level_t;

  // level indicator symbol codes, zero is dark
  localparam logic [2:0] SYM_DARK = 3'h0;

  typedef struct packed {
    pmfc_input_t     input_type;
    logic signed [31:0] scale_point_one_in;
    logic signed [31:0] scale_point_one_out;
    logic signed [31:0] scale_point_two_in;
    logic signed [31:0] scale_point_two_out;
    logic [15:0]     pulse_factor;   // display = freq * factor / 256
    logic            pulse_scaled;
    logic            avg_enable;
    logic [13:0]     hysteresis;
    logic [9:0]      startup_tenths;
    pmfc_colour_t    colour;
    pmfc_cmp_t       cmp_mode_one;
    pmfc_cmp_t       cmp_mode_two;
    logic [2:0]      decimal_point;
  } pmfc_cfg_t;

  typedef struct packed {
    logic level;
    logic mode;
    logic shift;
    logic up;
  } pmfc_keys_t;

  typedef struct packed {
    logic compare_output_one;
    logic compare_output_two;
    logic setpoint_view_indicator;
    logic teach_indicator;
    logic zero_indicator;
    logic hold_indicator;
    logic remote_write_indicator;
  } pmfc_status_t;
endpackage
`default_nettype wire

// *** tb/pmfc_chk.sv ***
// port checker for the panel meter front control
`timescale 1ns/100ps
`default_nettype none
module pmfc_chk
  import pmfc_pkg::*;
(
  input wire logic               clock,
  input wire logic               reset,
  input wire pmfc_keys_t         keys,
  input wire logic               hold_in,
  input wire logic               remote_write_en,
  input wire logic signed [31:0] display_value,
  input wire logic [19:0]        display_digits,
  input wire logic [2:0]         level_symbol,
  input wire logic [2:0]         param_index,
  input wire logic [2:0]         edit_digit,
  input wire logic               editing,
  input wire pmfc_status_t       status
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  ////////////////////////////////////////
  // no key last cycle, so the registered level view is current
  sequence s_quiet;
    $past(keys) == 4'h0 && !$past(reset);
  endsequence
  sequence s_zero_key;
    keys == 4'h1 && level_symbol == SYM_DARK && param_index == 3'h0 && !editing;
  endsequence
  property p_hold;
    !$past(reset) |-> status.hold_indicator == $past(hold_in);
  endproperty
  a_hold: assert property (p_hold) else $error("hold indicator wrong");
  property p_rwrite;
    !$past(reset) |-> status.remote_write_indicator == $past(remote_write_en);
  endproperty
  a_rwrite: assert property (p_rwrite) else $error("remote write indicator wrong");
  property p_sview;
    $past(editing) && !$past(reset) |-> status.setpoint_view_indicator;
  endproperty
  a_sview: assert property (p_sview) else $error("set view dark while editing");
  property p_level;
    keys.level |-> ##2 level_symbol != $past(level_symbol, 2);
  endproperty
  a_level: assert property (p_level) else $error("level key did not step level");
  property p_lrange;
    level_symbol <= 3'h6;
  endproperty
  a_lrange: assert property (p_lrange) else $error("level symbol out of range");
  property p_mode;
    keys.mode && !keys.level |=> param_index != $past(param_index) && param_index < NUM_PARAMS;
  endproperty
  a_mode: assert property (p_mode) else $error("mode key did not step parameter");
  property p_shift;
    keys.shift && !keys.level && !keys.mode && editing
      |=> edit_digit != $past(edit_digit) && edit_digit < NUM_DIGITS;
  endproperty
  a_shift: assert property (p_shift) else $error("shift did not move digit");
  property p_zero;
    s_quiet ##0 s_zero_key |-> ##2 status.zero_indicator != $past(status.zero_indicator, 2);
  endproperty
  a_zero: assert property (p_zero) else $error("up key did not toggle zero");
  property p_range;
    display_value >= DISP_MIN && display_value <= DISP_MAX;
  endproperty
  a_range: assert property (p_range) else $error("display value out of range");
  property p_blank;
    display_value == 32'sh0 && $past(display_value) == 32'sh0 |-> display_digits == 20'hffff0;
  endproperty
  a_blank: assert property (p_blank) else $error("zero not blanked");
endmodule
bind pmfc_top pmfc_chk pmfc_chk_i (.clock(clock), .reset(reset), .keys(keys),
  .hold_in(hold_in), .remote_write_en(remote_write_en), .display_value(display_value),
  .display_digits(display_digits), .level_symbol(level_symbol), .param_index(param_index),
  .edit_digit(edit_digit), .editing(editing), .status(status));
`default_nettype wire

// *** tb/pmfc_partner.sv ***
// operator keys and input converter model for the panel meter
`timescale 1ns/100ps
`default_nettype none
module pmfc_partner
  import pmfc_pkg::*;
(
  input  wire logic               clock,
  output var pmfc_keys_t          keys,
  output logic                    sample_valid,
  output logic signed [31:0]      sample_value
);
  initial
  begin
    keys = '0;
    sample_valid = 1'b0;
    sample_value = 32'sh0;
  end
  ////////////////////////////////////////
  // one-cycle press: 0 up, 1 shift, 2 mode, 3 level
  task automatic press(input int unsigned k);
    @(negedge clock);
    keys = pmfc_keys_t'(4'(1 << k));
    @(negedge clock);
    keys = '0;
  endtask
  // one sample; value scrambled once not valid, so stale data never matches
  task automatic send(input logic signed [31:0] v);
    @(negedge clock);
    sample_value = v;
    sample_valid = 1'b1;
    @(negedge clock);
    sample_valid = 1'b0;
    sample_value = ~v;
  endtask
endmodule
`default_nettype wire

// *** tb/pmfc_top_tb.sv ***
// self-checking testbench for the panel meter front control
`timescale 1ns/100ps
`default_nettype none
module pmfc_top_tb
  import pmfc_pkg::*;
;
  typedef struct packed {logic [7:0] kind; logic [31:0] exp;} pmfc_note_t;
  logic               clock, reset, sample_valid, hold_in, remote_write_en;
  logic               teach_enable, teach_request, cal_showing, cal_reading;
  logic               display_red, editing;
  logic [2:0]         decimal_point, level_symbol, param_index, edit_digit;
  logic [19:0]        display_digits;
  logic signed [31:0] sample_value, remote_value, display_value;
  logic signed [31:0] setpoint_one, setpoint_two;
  pmfc_cfg_t          cfg;
  pmfc_keys_t         keys;
  pmfc_status_t       status;
  pmfc_note_t         notes[$];
  pmfc_note_t         n;
  int                 num_errors = 0;
  int                 comparisons = 0;
  int                 cycles = 0;
  int                 i;
  pmfc_top pmfc_top_i (.clock(clock), .reset(reset), .cfg(cfg), .keys(keys),
    .sample_valid(sample_valid), .sample_value(sample_value), .remote_value(remote_value),
    .hold_in(hold_in), .remote_write_en(remote_write_en), .teach_enable(teach_enable),
    .teach_request(teach_request), .cal_showing(cal_showing), .cal_reading(cal_reading),
    .display_value(display_value), .display_digits(display_digits),
    .decimal_point(decimal_point), .display_red(display_red), .level_symbol(level_symbol),
    .param_index(param_index), .edit_digit(edit_digit), .editing(editing),
    .setpoint_one(setpoint_one), .setpoint_two(setpoint_two), .status(status));
  pmfc_partner pmfc_partner_i (.clock(clock), .keys(keys), .sample_valid(sample_valid),
    .sample_value(sample_value));
  ////////////////////////////////////////
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // kinds: 0 value, 1 digits, 2 point, 3 red, 4 level, 5/8 setpoints, 6 edit, 7 param, 1x status
  function automatic logic [31:0] actual(input logic [7:0] k);
    if (k[4]) return 32'(status[k[2:0]]);
    case (k)
      8'h0: return display_value;
      8'h1: return 32'(display_digits);
      8'h2: return 32'(decimal_point);
      8'h3: return 32'(display_red);
      8'h4: return 32'(level_symbol);
      8'h5: return setpoint_one;
      8'h6: return 32'({editing, edit_digit});
      8'h8: return setpoint_two;
      default: return 32'(param_index);
    endcase
  endfunction
  // watcher drains notes on falling edges, when registered outputs are settled
  always @(negedge clock)
    while (notes.size() > 0)
    begin
      n = notes.pop_front();
      comparisons = comparisons + 1;
      if (actual(n.kind) !== n.exp)
      begin
        num_errors = num_errors + 1;
        $display("MISMATCH %0t kind %0h got %0h want %0h", $time, n.kind, actual(n.kind), n.exp);
      end
    end
  // hang guard, far above the planned run
  always @(posedge clock)
  begin
    cycles = cycles + 1;
    if (cycles == 20000)
    begin
      num_errors = num_errors + 1;
      close_out();
    end
  end
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic note(input logic [7:0] k, input logic [31:0] v);
    notes.push_back('{k, v});
  endtask
  task automatic wt(input int c);
    repeat (c) @(posedge clock);
  endtask
  task automatic smp(input logic signed [31:0] v, input logic signed [31:0] e);
    pmfc_partner_i.send(v);
    wt(6);
    note(8'h0, e);
  endtask
  task automatic key(input int unsigned k);
    pmfc_partner_i.press(k);
    wt(2);
  endtask
  task automatic done(input string s);
    wt(1);
    $display("test %s finished", s);
  endtask
  task automatic do_reset();
    @(negedge clock);
    reset = 1'b1;
    wt(20);
    @(negedge clock);
    reset = 1'b0;
  endtask
  ////////////////////////////////////////
  // scaling gives display = 2 * input - 300; hysteresis band of 6
  initial
  begin
    int ins[7] = '{176, 173, 172, 100, 151, 153, 176};
    logic [1:0] outs[7] = '{2'h2, 2'h2, 2'h0, 2'h1, 2'h1, 2'h0, 2'h2};
    cfg = '0;
    cfg.input_type = PMFC_IN_CURRENT;
    cfg.scale_point_one_in = 32'sh64;
    cfg.scale_point_one_out = -32'sh64;
    cfg.scale_point_two_in = 32'sh258;
    cfg.scale_point_two_out = 32'sh384;
    cfg.hysteresis = 14'h6;
    cfg.cmp_mode_two = PMFC_CMP_LOWER;
    {hold_in, remote_write_en, teach_enable, teach_request, cal_showing, cal_reading} = '0;
    remote_value = 32'sh0;
    reset = 1'b1;
    i = $urandom(52);
    wt(20);
    @(negedge clock);
    reset = 1'b0;
    note(8'h1, 20'hffff0);
    for (i = 0; i < 4; i++)
    begin
      @(negedge clock);
      {hold_in, remote_write_en, teach_enable, cfg.decimal_point} = 6'($urandom);
      wt(2);
      note(8'h2, 32'(cfg.decimal_point));
      note(8'h11, 32'(hold_in));
      note(8'h10, 32'(remote_write_en));
      note(8'h13, 32'(teach_enable));
    end
    @(negedge clock);
    {hold_in, teach_enable, cal_showing} = 3'h1;
    wt(2);
    note(8'h13, 32'h1);
    @(negedge clock) cal_reading = 1'b1;
    wt(2);
    note(8'h13, 32'h0); // flashing, still in its dark half
    @(negedge clock) {cal_showing, cal_reading} = 2'h0;
    done("indicators");
    smp(50, -200);
    note(8'h1, 20'hfa200);
    smp(200000, 99999);
    note(8'h1, 20'h99999);
    smp(-30000, -19999);
    note(8'h1, 20'hb9999);
    i = 100 + ($urandom % 400);
    smp(i, 2 * i - 300);
    @(negedge clock) cfg.avg_enable = 1'b1;
    for (i = 1; i < 4; i++)
      pmfc_partner_i.send(100 * i);
    smp(400, 200);
    @(negedge clock) cfg.avg_enable = 1'b0;
    done("scaling");
    smp(175, 50);
    key(2);
    note(8'h7, 32'h1);
    note(8'h14, 32'h1);
    @(negedge clock);
    {teach_enable, teach_request} = 2'h3;
    @(negedge clock);
    {teach_enable, teach_request} = 2'h0;
    wt(2);
    note(8'h5, 32'sd50);
    repeat (3) key(2);
    note(8'h7, 32'h0);
    for (i = 0; i < 7; i++)
    begin
      smp(ins[i], 2 * ins[i] - 300);
      note(8'h16, 32'(outs[i][1]));
      note(8'h15, 32'(outs[i][0]));
    end
    for (i = 0; i < 4; i++)
    begin
      @(negedge clock);
      cfg.colour = pmfc_colour_t'(i);
      wt(2);
      note(8'h3, 32'(i == 0 || i == 2));
    end
    @(negedge clock) cfg.cmp_mode_one = PMFC_CMP_BAND;
    smp(160, 20);
    note(8'h16, 32'h0);
    smp(100, -100);
    note(8'h16, 32'h1);
    done("compare");
    key(2);
    key(1);
    note(8'h6, 32'h8);
    key(0);
    note(8'h5, 32'sd51);
    key(1);
    note(8'h6, 32'h9);
    repeat (5) key(0);
    note(8'h5, 32'sd1);
    key(2);
    key(1);
    key(0);
    note(8'h8, 32'sd1);
    for (i = 1; i < 8; i++)
    begin
      key(3);
      note(8'h4, 32'(i % 7));
    end
    done("keys");
    do_reset();
    note(8'h5, 32'h0);
    smp(175, 50);
    key(0);
    wt(4);
    note(8'h12, 32'h1);
    note(8'h0, 32'h0);
    key(0);
    wt(4);
    note(8'h12, 32'h0);
    note(8'h0, 32'sd50);
    done("zero");
    @(negedge clock) cfg.input_type = PMFC_IN_PULSE_HI;
    cfg.startup_tenths = 10'h1;
    smp(120, 120);
    note(8'h16, 32'h0); // still inside the startup time
    @(negedge clock) cfg.startup_tenths = 10'h0;
    wt(2);
    note(8'h16, 32'h1);
    @(negedge clock) {cfg.pulse_scaled, cfg.pulse_factor} = {1'b1, 16'h0280};
    smp(120, 300);
    @(negedge clock) cfg.input_type = PMFC_IN_PULSE_LO;
    cfg.pulse_scaled = 1'b0;
    smp(12, 12);
    @(negedge clock);
    cfg.input_type = PMFC_IN_REMOTE;
    remote_value = $urandom % 100000;
    wt(6);
    note(8'h0, remote_value);
    done("pulse and remote");
    wt(2);
    close_out();
  end
endmodule
`default_nettype wire
